/* File: common/acs_pkg.sv */
// Purpose: shared constants and types of the atomic compare and conditional store unit
// Assumes: one core clock, 32-bit data path
// Notes:   special register selector and field positions live here only
package acs_pkg;
  localparam int           DATA_W       = 32;
  localparam int           ADDR_W       = 32;
  localparam int           SR_SEL_W     = 8;
  localparam int           IMM_W        = 8;
  localparam int           IMM_SHIFT    = 2;
  localparam int           DREG_W       = 4;
  localparam logic [7:0]   SR_COMPARE   = 8'h0C;
  localparam logic [1:0]   WORD_ALIGN   = 2'h0;
  localparam logic [31:0]  RESULT_CLEAR = 32'h0000_0000;

  typedef enum logic [1:0] {
    OP_SR_READ  = 2'b00,
    OP_SR_WRITE = 2'b01,
    OP_SR_SWAP  = 2'b10,
    OP_CSTORE   = 2'b11
  } acs_op_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DRAIN = 2'b01,
    ST_BUS   = 2'b10,
    ST_RESP  = 2'b11
  } acs_state_type;
endpackage : acs_pkg

/* File: verilog/acs_expect_reg.sv */
// Purpose: expected-value special register with read, write and swap access
// Assumes: caller issues at most one access per cycle
// Notes:   data register, not cleared by reset
`timescale 1ns/100ps
module acs_expect_reg (
  input  wire logic                       clk,
  input  wire logic                       wr_en,
  input  wire logic [acs_pkg::DATA_W-1:0] wr_data,
  output logic      [acs_pkg::DATA_W-1:0] value
);
  logic [acs_pkg::DATA_W-1:0] value_r;
  logic [acs_pkg::DATA_W-1:0] value_nxt;

  always_comb begin
    value_nxt = value_r;
    if (wr_en) begin
      value_nxt = wr_data;
    end
  end

  // no reset: content undefined until software writes it
  always_ff @(posedge clk) begin
    value_r <= value_nxt;
  end

  assign value = value_r;
endmodule : acs_expect_reg

/* File: verilog/acs_top.sv */
// Purpose: conditional store unit with expected-value register and atomic bus pair
// Assumes: prior_done comes from the load/store unit on the same clock
// Notes:   later accesses must honour order_hold while it is high
`timescale 1ns/100ps
module acs_top (
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire logic                         instr_valid,
  input  wire acs_pkg::acs_op_type          instr_op,
  input  wire logic [acs_pkg::SR_SEL_W-1:0] instr_sr_sel,
  input  wire logic [acs_pkg::ADDR_W-1:0]   instr_base,
  input  wire logic [acs_pkg::IMM_W-1:0]    instr_imm,
  input  wire logic [acs_pkg::DATA_W-1:0]   instr_data,
  input  wire logic [acs_pkg::DREG_W-1:0]   instr_dreg,
  input  wire logic                         instr_bypass,
  input  wire logic                         prior_done,
  input  wire logic                         bus_ready,
  input  wire logic                         bus_rsp_valid,
  input  wire logic [acs_pkg::DATA_W-1:0]   bus_rsp_data,
  output logic                              instr_ready,
  output logic                              order_hold,
  output logic                              bus_valid,
  output logic                              bus_lock,
  output logic      [acs_pkg::ADDR_W-1:0]   bus_addr,
  output logic      [acs_pkg::DATA_W-1:0]   bus_cmp_data,
  output logic      [acs_pkg::DATA_W-1:0]   bus_new_data,
  output logic                              result_valid,
  output logic      [acs_pkg::DATA_W-1:0]   result_data,
  output logic      [acs_pkg::DREG_W-1:0]   result_dreg,
  output logic                              result_fault
);
  acs_pkg::acs_state_type     state_r;
  acs_pkg::acs_state_type     state_nxt;
  logic                       ready_r;
  logic                       ready_nxt;
  logic                       hold_r;
  logic                       hold_nxt;
  logic                       bvalid_r;
  logic                       bvalid_nxt;
  logic                       lock_r;
  logic                       lock_nxt;
  logic [acs_pkg::ADDR_W-1:0] addr_r;
  logic [acs_pkg::ADDR_W-1:0] addr_nxt;
  logic [acs_pkg::DATA_W-1:0] cmp_r;
  logic [acs_pkg::DATA_W-1:0] cmp_nxt;
  logic [acs_pkg::DATA_W-1:0] new_r;
  logic [acs_pkg::DATA_W-1:0] new_nxt;
  logic                       rvalid_r;
  logic                       rvalid_nxt;
  logic [acs_pkg::DATA_W-1:0] rdata_r;
  logic [acs_pkg::DATA_W-1:0] rdata_nxt;
  logic [acs_pkg::DREG_W-1:0] rdreg_r;
  logic [acs_pkg::DREG_W-1:0] rdreg_nxt;
  logic                       fault_r;
  logic                       fault_nxt;
  logic                       sr_wr;
  logic [acs_pkg::DATA_W-1:0] sr_value;
  logic                       accept;
  logic                       sel_ok;

  function automatic logic [acs_pkg::ADDR_W-1:0] eff_addr(
    input logic [acs_pkg::ADDR_W-1:0] base,
    input logic [acs_pkg::IMM_W-1:0]  imm
  );
    logic [acs_pkg::ADDR_W-1:0] ofs;
    ofs = {{(acs_pkg::ADDR_W-acs_pkg::IMM_W-acs_pkg::IMM_SHIFT){1'b0}}, imm,
           acs_pkg::WORD_ALIGN};
    return acs_pkg::ADDR_W'(base + ofs);
  endfunction : eff_addr

  assign accept = instr_valid & ready_r;
  assign sel_ok = (instr_sr_sel == acs_pkg::SR_COMPARE);
  assign sr_wr  = accept & sel_ok & ((instr_op == acs_pkg::OP_SR_WRITE) |
                                     (instr_op == acs_pkg::OP_SR_SWAP));

  acs_expect_reg u_expect (
    .clk     (clk),
    .wr_en   (sr_wr),
    .wr_data (instr_data),
    .value   (sr_value)
  );

  always_comb begin
    state_nxt  = state_r;
    hold_nxt   = hold_r;
    bvalid_nxt = bvalid_r;
    lock_nxt   = lock_r;
    addr_nxt   = addr_r;
    cmp_nxt    = cmp_r;
    new_nxt    = new_r;
    rvalid_nxt = 1'b0;
    rdata_nxt  = rdata_r;
    rdreg_nxt  = rdreg_r;
    fault_nxt  = fault_r;
    case (state_r)
      acs_pkg::ST_IDLE: begin
        if (accept) begin
          rdreg_nxt = instr_dreg;
          case (instr_op)
            acs_pkg::OP_SR_READ, acs_pkg::OP_SR_SWAP: begin
              rvalid_nxt = 1'b1;
              rdata_nxt  = sel_ok ? sr_value : acs_pkg::RESULT_CLEAR;
              fault_nxt  = ~sel_ok;
            end
            acs_pkg::OP_SR_WRITE: begin
              fault_nxt = ~sel_ok;
            end
            acs_pkg::OP_CSTORE: begin
              if (instr_bypass) begin
                addr_nxt  = eff_addr(instr_base, instr_imm);
                cmp_nxt   = sr_value;
                new_nxt   = instr_data;
                hold_nxt  = 1'b1;
                fault_nxt = 1'b0;
                state_nxt = acs_pkg::ST_DRAIN;
              end else begin
                rvalid_nxt = 1'b1;
                rdata_nxt  = acs_pkg::RESULT_CLEAR;
                fault_nxt  = 1'b1;
              end
            end
            default: begin
              fault_nxt = 1'b1;
            end
          endcase
        end
      end
      acs_pkg::ST_DRAIN: begin
        if (prior_done) begin
          bvalid_nxt = 1'b1;
          lock_nxt   = 1'b1;
          state_nxt  = acs_pkg::ST_BUS;
        end
      end
      acs_pkg::ST_BUS: begin
        if (bus_ready) begin
          bvalid_nxt = 1'b0;
          state_nxt  = acs_pkg::ST_RESP;
        end
      end
      acs_pkg::ST_RESP: begin
        if (bus_rsp_valid) begin
          lock_nxt   = 1'b0;
          hold_nxt   = 1'b0;
          rvalid_nxt = 1'b1;
          rdata_nxt  = bus_rsp_data;
          state_nxt  = acs_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = acs_pkg::ST_IDLE;
      end
    endcase
    ready_nxt = (state_nxt == acs_pkg::ST_IDLE);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r  <= acs_pkg::ST_IDLE;
      ready_r  <= 1'b1;
      hold_r   <= 1'b0;
      bvalid_r <= 1'b0;
      lock_r   <= 1'b0;
      addr_r   <= '0;
      cmp_r    <= '0;
      new_r    <= '0;
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rdreg_r  <= '0;
      fault_r  <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      ready_r  <= ready_nxt;
      hold_r   <= hold_nxt;
      bvalid_r <= bvalid_nxt;
      lock_r   <= lock_nxt;
      addr_r   <= addr_nxt;
      cmp_r    <= cmp_nxt;
      new_r    <= new_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      rdreg_r  <= rdreg_nxt;
      fault_r  <= fault_nxt;
    end
  end

  assign instr_ready  = ready_r;
  assign order_hold   = hold_r;
  assign bus_valid    = bvalid_r;
  assign bus_lock     = lock_r;
  assign bus_addr     = addr_r;
  assign bus_cmp_data = cmp_r;
  assign bus_new_data = new_r;
  assign result_valid = rvalid_r;
  assign result_data  = rdata_r;
  assign result_dreg  = rdreg_r;
  assign result_fault = fault_r;

  property p_cmp_operand;
    @(posedge clk) disable iff (!rstn)
      bvalid_r |-> (cmp_r == sr_value);
  endproperty
  a_cmp_operand: assert property (p_cmp_operand) else $error("compare operand differs");

  property p_lock_span;
    @(posedge clk) disable iff (!rstn)
      (state_r == acs_pkg::ST_BUS || state_r == acs_pkg::ST_RESP) |-> lock_r;
  endproperty
  a_lock_span: assert property (p_lock_span) else $error("lock dropped mid pair");

  property p_old_value;
    @(posedge clk) disable iff (!rstn)
      (state_r == acs_pkg::ST_RESP && bus_rsp_valid) |=>
        (rvalid_r && rdata_r == $past(bus_rsp_data) && !lock_r && ready_r);
  endproperty
  a_old_value: assert property (p_old_value) else $error("old value not returned");

  property p_sr_read;
    @(posedge clk) disable iff (!rstn)
      (accept && sel_ok && instr_op == acs_pkg::OP_SR_READ) |=>
        (rvalid_r && !fault_r && rdata_r == $past(sr_value));
  endproperty
  a_sr_read: assert property (p_sr_read) else $error("register read wrong");

  property p_sr_swap;
    @(posedge clk) disable iff (!rstn)
      (accept && sel_ok && instr_op == acs_pkg::OP_SR_SWAP) |=>
        (sr_value == $past(instr_data) && rdata_r == $past(sr_value));
  endproperty
  a_sr_swap: assert property (p_sr_swap) else $error("register swap wrong");

  property p_bypass_only;
    @(posedge clk) disable iff (!rstn)
      (accept && instr_op == acs_pkg::OP_CSTORE && !instr_bypass) |=>
        (rvalid_r && fault_r && state_r == acs_pkg::ST_IDLE) ##1 !bvalid_r;
  endproperty
  a_bypass_only: assert property (p_bypass_only) else $error("cached store issued");

  property p_drain;
    @(posedge clk) disable iff (!rstn)
      $rose(bvalid_r) |-> $past(prior_done) && $past(state_r == acs_pkg::ST_DRAIN);
  endproperty
  a_drain: assert property (p_drain) else $error("pair issued before drain");

  property p_hold_later;
    @(posedge clk) disable iff (!rstn)
      (state_r != acs_pkg::ST_IDLE) |-> (hold_r && !ready_r);
  endproperty
  a_hold_later: assert property (p_hold_later) else $error("later access released");

  property p_addr;
    @(posedge clk) disable iff (!rstn)
      (accept && instr_op == acs_pkg::OP_CSTORE && instr_bypass) |=>
        (addr_r == $past(instr_base) + {$past(instr_imm), 2'b00});
  endproperty
  a_addr: assert property (p_addr) else $error("address wrong");

  c_atomic: cover property (@(posedge clk) disable iff (!rstn)
    (state_r == acs_pkg::ST_RESP && bus_rsp_valid) ##1 rvalid_r);
  c_drain_wait: cover property (@(posedge clk) disable iff (!rstn)
    (state_r == acs_pkg::ST_DRAIN && !prior_done) [*3] ##1 prior_done ##1 bvalid_r);
  c_swap: cover property (@(posedge clk) disable iff (!rstn)
    accept && sel_ok && instr_op == acs_pkg::OP_SR_SWAP);
endmodule : acs_top

/* File: tb/acs_mem_model.sv */
// Purpose: shared memory behind the system bus, atomic read-compare-write
// Assumes: one locked pair at a time, word index from bus_addr[5:2]
// Notes:   stall holds off bus_ready; idle response data toggles
`timescale 1ns/100ps
module acs_mem_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        stall,
  input  wire logic        bus_valid,
  input  wire logic        bus_lock,
  input  wire logic [31:0] bus_addr,
  input  wire logic [31:0] bus_cmp_data,
  input  wire logic [31:0] bus_new_data,
  output logic             bus_ready,
  output logic             bus_rsp_valid,
  output logic      [31:0] bus_rsp_data
);
  logic [31:0] mem [0:15];
  logic        pend;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_ready     <= 1'b0;
      bus_rsp_valid <= 1'b0;
      bus_rsp_data  <= 32'h0000_0000;
      pend          <= 1'b0;
    end else begin
      bus_ready     <= bus_valid && !bus_ready && !stall;
      bus_rsp_valid <= 1'b0;
      bus_rsp_data  <= ~bus_rsp_data;
      if (bus_valid && bus_ready) begin
        pend <= bus_lock;
      end else if (pend) begin
        pend          <= 1'b0;
        bus_rsp_valid <= 1'b1;
        bus_rsp_data  <= mem[bus_addr[5:2]];
        if (mem[bus_addr[5:2]] === bus_cmp_data) begin
          mem[bus_addr[5:2]] <= bus_new_data;
        end
      end
    end
  end
endmodule : acs_mem_model

/* File: tb/acs_top_tb_top.sv */
// Purpose: directed checks of the conditional store unit
// Assumes: memory model answers the locked pair
// Notes:   expected values come from the stimulus only
`timescale 1ns/100ps
module acs_top_tb_top;
  localparam logic [31:0] BASE = 32'h2000_0000;
  logic                clk, rstn, instr_valid, instr_bypass, prior_done, stall;
  acs_pkg::acs_op_type instr_op;
  logic [7:0]          instr_sr_sel, instr_imm;
  logic [31:0]         instr_base, instr_data, bus_addr, bus_cmp_data, bus_new_data;
  logic [3:0]          instr_dreg, result_dreg;
  logic                bus_ready, bus_rsp_valid, instr_ready, order_hold, bus_valid;
  logic                bus_lock, result_valid, result_fault;
  logic [31:0]         bus_rsp_data, result_data;
  int                  mismatches, cmp_count;
  acs_top DUT (
    .clk          (clk),
    .rstn         (rstn),
    .instr_valid  (instr_valid),
    .instr_op     (instr_op),
    .instr_sr_sel (instr_sr_sel),
    .instr_base   (instr_base),
    .instr_imm    (instr_imm),
    .instr_data   (instr_data),
    .instr_dreg   (instr_dreg),
    .instr_bypass (instr_bypass),
    .prior_done   (prior_done),
    .bus_ready    (bus_ready),
    .bus_rsp_valid(bus_rsp_valid),
    .bus_rsp_data (bus_rsp_data),
    .instr_ready  (instr_ready),
    .order_hold   (order_hold),
    .bus_valid    (bus_valid),
    .bus_lock     (bus_lock),
    .bus_addr     (bus_addr),
    .bus_cmp_data (bus_cmp_data),
    .bus_new_data (bus_new_data),
    .result_valid (result_valid),
    .result_data  (result_data),
    .result_dreg  (result_dreg),
    .result_fault (result_fault)
  );
  acs_mem_model mem_i (
    .clk          (clk),
    .rstn         (rstn),
    .stall        (stall),
    .bus_valid    (bus_valid),
    .bus_lock     (bus_lock),
    .bus_addr     (bus_addr),
    .bus_cmp_data (bus_cmp_data),
    .bus_new_data (bus_new_data),
    .bus_ready    (bus_ready),
    .bus_rsp_valid(bus_rsp_valid),
    .bus_rsp_data (bus_rsp_data)
  );
  always #20 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic issue(input acs_pkg::acs_op_type op, input logic [7:0] sel,
                       input logic [31:0] d, input logic [7:0] imm, input logic byp);
    int n;
    @(posedge clk);
    instr_valid  <= 1'b1;
    instr_op     <= op;
    instr_sr_sel <= sel;
    instr_imm    <= imm;
    instr_data   <= d;
    instr_dreg   <= {2'b01, op};
    instr_bypass <= byp;
    n = 0;
    do @(posedge clk); while (instr_ready !== 1'b1 && ++n < 60);
    instr_valid <= 1'b0;
  endtask : issue
  task automatic res(input logic [31:0] d, input logic f, input acs_pkg::acs_op_type op);
    int n;
    n = 0;
    do @(negedge clk); while (result_valid !== 1'b1 && ++n < 80);
    chk("result_valid", 32'h1, {31'h0, result_valid});
    chk("result_data", d, result_data);
    chk("result_fault", {31'h0, f}, {31'h0, result_fault});
    chk("result_dreg", {28'h0, 2'b01, op}, {28'h0, result_dreg});
  endtask : res
  task automatic cas(input logic [31:0] nv, input logic [31:0] old,
                     input logic [31:0] fin, input logic stl);
    @(posedge clk);
    prior_done <= 1'b0;
    stall      <= stl;
    issue(acs_pkg::OP_CSTORE, 8'h00, nv, 8'hFF, 1'b1);
    repeat (4) @(negedge clk);
    chk("bus_valid", 32'h0, {31'h0, bus_valid});
    chk("order_hold", 32'h1, {31'h0, order_hold});
    chk("instr_ready", 32'h0, {31'h0, instr_ready});
    chk("bus_addr", BASE + 32'h3FC, bus_addr);
    chk("bus_cmp_data", 32'h1234_5678, bus_cmp_data);
    chk("bus_new_data", nv, bus_new_data);
    @(posedge clk);
    prior_done <= 1'b1;
    repeat (4) @(negedge clk);
    chk("bus_lock", 32'h1, {31'h0, bus_lock});
    @(posedge clk);
    stall <= 1'b0;
    res(old, 1'b0, acs_pkg::OP_CSTORE);
    chk("order_hold", 32'h0, {31'h0, order_hold});
    chk("instr_ready", 32'h1, {31'h0, instr_ready});
    chk("bus_lock", 32'h0, {31'h0, bus_lock});
    chk("memory word", fin, mem_i.mem[15]);
  endtask : cas
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (6000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    clk          = 1'b0;
    rstn         = 1'b0;
    instr_valid  = 1'b0;
    instr_op     = acs_pkg::OP_SR_READ;
    instr_sr_sel = 8'h00;
    instr_imm    = 8'h00;
    instr_base   = BASE;
    instr_data   = 32'h0000_0000;
    instr_dreg   = 4'h0;
    instr_bypass = 1'b0;
    prior_done   = 1'b1;
    stall        = 1'b0;
    mismatches   = 0;
    cmp_count    = 0;
    mem_i.mem[15] = 32'h1234_5678;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    issue(acs_pkg::OP_SR_WRITE, acs_pkg::SR_COMPARE, 32'h0BAD_F00D, 8'h00, 1'b0);
    issue(acs_pkg::OP_SR_READ, acs_pkg::SR_COMPARE, 32'h0000_0000, 8'h00, 1'b0);
    res(32'h0BAD_F00D, 1'b0, acs_pkg::OP_SR_READ);
    issue(acs_pkg::OP_SR_SWAP, acs_pkg::SR_COMPARE, 32'h1234_5678, 8'h00, 1'b0);
    res(32'h0BAD_F00D, 1'b0, acs_pkg::OP_SR_SWAP);
    issue(acs_pkg::OP_SR_READ, 8'h0D, 32'h0000_0000, 8'h00, 1'b0);
    res(32'h0000_0000, 1'b1, acs_pkg::OP_SR_READ);
    issue(acs_pkg::OP_SR_WRITE, 8'h0B, 32'hFFFF_FFFF, 8'h00, 1'b0);
    @(negedge clk);
    chk("result_fault", 32'h1, {31'h0, result_fault});
    chk("result_valid", 32'h0, {31'h0, result_valid});
    issue(acs_pkg::OP_SR_READ, acs_pkg::SR_COMPARE, 32'h0000_0000, 8'h00, 1'b0);
    res(32'h1234_5678, 1'b0, acs_pkg::OP_SR_READ);
    cas(32'h0000_0001, 32'h1234_5678, 32'h0000_0001, 1'b0);
    cas(32'h0000_0002, 32'h0000_0001, 32'h0000_0001, 1'b1);
    issue(acs_pkg::OP_CSTORE, 8'h00, 32'h0000_0003, 8'h01, 1'b0);
    res(32'h0000_0000, 1'b1, acs_pkg::OP_CSTORE);
    chk("bus_valid", 32'h0, {31'h0, bus_valid});
    tally_and_finish();
  end
endmodule : acs_top_tb_top
